/* design/fsp_seq.sv */
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "fsp_cfg.svh"
module fsp_seq #(
	parameter int ADDR_W = 16,
	parameter int PAGE_B = 8,
	parameter int NUM_PAGES = 256,
	parameter int BOOT_PAGE = 240,
	parameter int ERASE_CYC = `FSP_ERASE_CYC,
	parameter int WRITE_CYC = `FSP_WRITE_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// processor side
	input wire logic pm_store,
	input wire logic pm_load,
	input wire logic [ADDR_W-1:0] pm_ptr,
	output logic pm_load_hit,
	output logic [7:0] pm_load_data,
	output logic cpu_halt,
	// flash array side
	output logic fl_erase,
	output logic fl_write,
	output logic fl_whole,
	output logic fl_sigrow,
	output logic [ADDR_W-PAGE_B-1:0] fl_page,
	output logic [ADDR_W-1:0] fl_rd_addr,
	input wire logic [7:0] fl_rd_data,
	output logic pb_clear,
	output logic flash_section_busy,
	// signature rows, fuses, locks
	input wire logic [7:0] sig_user_data,
	input wire logic [7:0] sig_prod_data,
	output logic [7:0] fuse_addr,
	input wire logic [7:0] fuse_data,
	output logic lock_wr,
	output logic [7:0] lock_wr_data,
	input wire logic [1:0] boot_lock_bits
);
	localparam int PW = ADDR_W - PAGE_B;
	localparam int CNT_W = 16;

	if (PAGE_B < 1 || PAGE_B >= ADDR_W || BOOT_PAGE >= NUM_PAGES ||
		NUM_PAGES > 2 ** PW || ERASE_CYC < 1 || WRITE_CYC < 1 ||
		ERASE_CYC >= 2 ** CNT_W || WRITE_CYC >= 2 ** CNT_W) begin : g_bad_param
		$error("fsp_seq: unsupported parameters");
	end

	typedef struct packed {
		fsp_pkg::fsp_state_e st;
		logic [6:0] cmd;
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic abort;
		logic [3:0] guard;
		logic [CNT_W-1:0] cnt;
		logic [PW-1:0] page;
		logic whole;
		logic sig;
		logic then_wr;
		logic clr_after;
		logic halt;
		logic [ADDR_W-1:0] rd_ptr;
		logic [ADDR_W-1:0] end_ptr;
		logic issue;
		logic rd_pend;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic ld_hit;
		logic [7:0] ld_data;
		logic lock_wr;
		logic pb_clr;
		logic [1:0] lk_s1;
		logic [1:0] lk_s2;
	} fsp_seq_s;

	fsp_seq_s s_r;
	fsp_seq_s s_nxt;
	logic [15:0] crc;
	logic crc_init;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic f_mapped(input logic [7:0] a);
		return a == `FSP_OFF_CMD || a == `FSP_OFF_CTRLA ||
			a == `FSP_OFF_STATUS || a == `FSP_OFF_ADDR ||
			a == `FSP_OFF_DATA || a == `FSP_OFF_GUARD;
	endfunction

	function automatic logic [31:0] f_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic fsp_pkg::fsp_trig_e f_trig(input logic [6:0] c);
		case (c)
			fsp_pkg::cmd_rd_fuse, fsp_pkg::cmd_wr_lock,
			fsp_pkg::cmd_crc_app, fsp_pkg::cmd_crc_boot,
			fsp_pkg::cmd_crc_rng: return fsp_pkg::trg_exec;
			fsp_pkg::cmd_rd_usig, fsp_pkg::cmd_rd_psig:
				return fsp_pkg::trg_load;
			fsp_pkg::cmd_er_usig, fsp_pkg::cmd_wr_usig, fsp_pkg::cmd_er_app,
			fsp_pkg::cmd_er_apg, fsp_pkg::cmd_wr_apg, fsp_pkg::cmd_ew_apg,
			fsp_pkg::cmd_er_bpg, fsp_pkg::cmd_wr_bpg,
			fsp_pkg::cmd_ew_bpg: return fsp_pkg::trg_store;
			default: return fsp_pkg::trg_none;
		endcase
	endfunction

	function automatic logic f_prot(input logic [6:0] c);
		return c != fsp_pkg::cmd_rd_fuse;
	endfunction

	logic [PW-1:0] ptr_page;
	logic app_ok;
	logic boot_ok;
	logic w_fire;
	logic exec;
	logic trig;
	logic trig_ok;
	logic lock_free;
	logic [ADDR_W-1:0] app_end;
	logic [ADDR_W-1:0] boot_beg;
	logic [ADDR_W-1:0] boot_end;

	assign ptr_page = pm_ptr[ADDR_W-1:PAGE_B];
	assign app_ok = ptr_page < PW'(BOOT_PAGE);
	assign boot_ok = !app_ok && int'(ptr_page) < NUM_PAGES;
	assign app_end = ADDR_W'(BOOT_PAGE * (2 ** PAGE_B) - 1);
	assign boot_beg = ADDR_W'(BOOT_PAGE * (2 ** PAGE_B));
	assign boot_end = ADDR_W'(NUM_PAGES * (2 ** PAGE_B) - 1);
	assign lock_free = &s_r.lk_s2;
	assign w_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
	assign exec = w_fire && s_r.awaddr == `FSP_OFF_CTRLA &&
		s_r.wstrb[0] && s_r.wdata[`FSP_CTRLA_EXEC];
	always_comb begin
		case (f_trig(s_r.cmd))
			fsp_pkg::trg_exec: trig = exec;
			fsp_pkg::trg_store: trig = pm_store;
			default: trig = 1'b0;
		endcase
	end
	assign trig_ok = s_r.guard != 4'h0 || !f_prot(s_r.cmd);
	assign crc_init = s_nxt.st == fsp_pkg::st_crc && s_r.st != fsp_pkg::st_crc;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.lk_s1 = boot_lock_bits;
		s_nxt.lk_s2 = s_r.lk_s1;
		s_nxt.ld_hit = 1'b0;
		s_nxt.lock_wr = 1'b0;
		s_nxt.pb_clr = 1'b0;
		if (s_r.guard != 4'h0) begin
			s_nxt.guard = s_r.guard - 4'h1;
		end
		// bus write channel
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (w_fire) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = f_mapped(s_r.awaddr) ? `FSP_RESP_OK : `FSP_RESP_ERR;
			case (s_r.awaddr)
				`FSP_OFF_CMD: if (s_r.wstrb[0]) s_nxt.cmd = s_r.wdata[6:0];
				`FSP_OFF_ADDR: s_nxt.addr = ADDR_W'(f_merge(32'(s_r.addr),
					s_r.wdata, s_r.wstrb));
				`FSP_OFF_DATA: s_nxt.data = f_merge(s_r.data, s_r.wdata,
					s_r.wstrb);
				`FSP_OFF_STATUS: if (s_r.wstrb[0] &&
					s_r.wdata[`FSP_ST_ABORT]) s_nxt.abort = 1'b0;
				`FSP_OFF_GUARD: if (s_r.wstrb[0] &&
					s_r.wdata[7:0] == `FSP_GUARD_KEY) s_nxt.guard = 4'(`FSP_GUARD_CYC);
				default: ;
			endcase
		end
		// bus read channel
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = f_mapped(s_axi_araddr) ? `FSP_RESP_OK : `FSP_RESP_ERR;
			case (s_axi_araddr)
				`FSP_OFF_CMD: s_nxt.rdata = {25'h0000000, s_r.cmd};
				`FSP_OFF_STATUS: s_nxt.rdata = {27'h0000000, s_r.guard != 4'h0,
					s_r.abort, s_r.halt, flash_section_busy,
					s_r.st != fsp_pkg::st_idle};
				`FSP_OFF_ADDR: s_nxt.rdata = 32'(s_r.addr);
				`FSP_OFF_DATA: s_nxt.rdata = s_r.data;
				default: s_nxt.rdata = 32'h00000000;
			endcase
		end
		// signature row read redirect
		if (pm_load && s_r.st == fsp_pkg::st_idle &&
			f_trig(s_r.cmd) == fsp_pkg::trg_load) begin
			s_nxt.ld_hit = 1'b1;
			s_nxt.ld_data = s_r.cmd == fsp_pkg::cmd_rd_usig ?
				sig_user_data : sig_prod_data;
		end
		// sequencer
		if (s_r.cnt != CNT_W'(0)) begin
			s_nxt.cnt = s_r.cnt - CNT_W'(1);
		end
		case (s_r.st)
			fsp_pkg::st_idle: begin
				s_nxt.halt = 1'b0;
				s_nxt.whole = 1'b0;
				s_nxt.sig = 1'b0;
				s_nxt.then_wr = 1'b0;
				s_nxt.clr_after = 1'b0;
				if (trig && trig_ok) begin
					s_nxt.guard = 4'h0;
					s_nxt.page = ptr_page;
					s_nxt.cnt = CNT_W'(ERASE_CYC - 1);
					case (s_r.cmd)
						fsp_pkg::cmd_er_app: begin
							s_nxt.whole = 1'b1;
							s_nxt.halt = app_ok;
							s_nxt.st = app_ok ? fsp_pkg::st_erase : fsp_pkg::st_idle;
							if (!app_ok) begin
								s_nxt.abort = 1'b1;
							end
						end
						fsp_pkg::cmd_er_apg, fsp_pkg::cmd_er_bpg,
						fsp_pkg::cmd_ew_apg, fsp_pkg::cmd_ew_bpg: begin
							if ((s_r.cmd[3] ? boot_ok : app_ok)) begin
								s_nxt.st = fsp_pkg::st_erase;
								s_nxt.then_wr = s_r.cmd[0];
							end else begin
								s_nxt.abort = 1'b1;
							end
						end
						fsp_pkg::cmd_wr_apg, fsp_pkg::cmd_wr_bpg: begin
							s_nxt.cnt = CNT_W'(WRITE_CYC - 1);
							if ((s_r.cmd[3] ? boot_ok : app_ok)) begin
								s_nxt.st = fsp_pkg::st_write;
							end else begin
								s_nxt.abort = 1'b1;
							end
						end
						fsp_pkg::cmd_er_usig: begin
							s_nxt.st = fsp_pkg::st_erase;
							s_nxt.sig = 1'b1;
							s_nxt.halt = 1'b1;
						end
						fsp_pkg::cmd_wr_usig: begin
							s_nxt.st = fsp_pkg::st_write;
							s_nxt.cnt = CNT_W'(WRITE_CYC - 1);
							s_nxt.sig = 1'b1;
							s_nxt.halt = 1'b1;
							s_nxt.clr_after = 1'b1;
						end
						fsp_pkg::cmd_crc_rng, fsp_pkg::cmd_crc_app,
						fsp_pkg::cmd_crc_boot: begin
							case (s_r.cmd)
								fsp_pkg::cmd_crc_rng: begin
									s_nxt.rd_ptr = s_r.addr;
									s_nxt.end_ptr = s_r.data[ADDR_W-1:0];
								end
								fsp_pkg::cmd_crc_app: begin
									s_nxt.rd_ptr = '0;
									s_nxt.end_ptr = app_end;
								end
								default: begin
									s_nxt.rd_ptr = boot_beg;
									s_nxt.end_ptr = boot_end;
								end
							endcase
							if (s_r.cmd == fsp_pkg::cmd_crc_rng && (!lock_free ||
								s_r.addr > s_r.data[ADDR_W-1:0])) begin
								s_nxt.abort = 1'b1;
							end else begin
								s_nxt.st = fsp_pkg::st_crc;
								s_nxt.halt = 1'b1;
								s_nxt.issue = 1'b1;
							end
						end
						fsp_pkg::cmd_rd_fuse: begin
							s_nxt.st = fsp_pkg::st_fuse;
							s_nxt.halt = 1'b1;
							s_nxt.cnt = CNT_W'(`FSP_FUSE_CYC - 1);
						end
						fsp_pkg::cmd_wr_lock: begin
							s_nxt.st = fsp_pkg::st_lock;
							s_nxt.cnt = CNT_W'(`FSP_LOCK_CYC - 1);
						end
						default: ;
					endcase
				end
			end
			fsp_pkg::st_erase: if (s_r.cnt == CNT_W'(0)) begin
				s_nxt.st = s_r.then_wr ? fsp_pkg::st_write : fsp_pkg::st_idle;
				s_nxt.cnt = CNT_W'(WRITE_CYC - 1);
			end
			fsp_pkg::st_write: if (s_r.cnt == CNT_W'(0)) begin
				s_nxt.st = s_r.clr_after ? fsp_pkg::st_clr : fsp_pkg::st_idle;
				s_nxt.halt = 1'b0;
				s_nxt.pb_clr = s_r.clr_after;
				s_nxt.cnt = CNT_W'(`FSP_CLR_CYC - 1);
			end
			fsp_pkg::st_clr: if (s_r.cnt == CNT_W'(0)) begin
				s_nxt.st = fsp_pkg::st_idle;
			end
			fsp_pkg::st_crc: begin
				s_nxt.rd_pend = s_r.issue;
				if (s_r.issue) begin
					if (s_r.rd_ptr == s_r.end_ptr) begin
						s_nxt.issue = 1'b0;
					end else begin
						s_nxt.rd_ptr = s_r.rd_ptr + ADDR_W'(1);
					end
				end else if (!s_r.rd_pend) begin
					s_nxt.data = {16'h0000, crc};
					s_nxt.st = fsp_pkg::st_idle;
				end
			end
			fsp_pkg::st_fuse: if (s_r.cnt == CNT_W'(0)) begin
				s_nxt.data = {24'h000000, fuse_data};
				s_nxt.st = fsp_pkg::st_idle;
			end
			fsp_pkg::st_lock: if (s_r.cnt == CNT_W'(0)) begin
				s_nxt.lock_wr = 1'b1;
				s_nxt.pb_clr = 1'b1;
				s_nxt.st = fsp_pkg::st_idle;
			end
			default: s_nxt.st = fsp_pkg::st_idle;
		endcase
		// halt and target flags drop with busy
		if (s_nxt.st == fsp_pkg::st_idle) begin
			s_nxt.halt = 1'b0;
			s_nxt.whole = 1'b0;
			s_nxt.sig = 1'b0;
			s_nxt.then_wr = 1'b0;
			s_nxt.clr_after = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.st <= fsp_pkg::st_idle;
			s_r.cmd <= `FSP_CMD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	fsp_crc16 u_crc (
		.aclk(aclk),
		.aresetn(aresetn),
		.init(crc_init),
		.en(s_r.rd_pend),
		.din(fl_rd_data),
		.crc(crc)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
	assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign pm_load_hit = s_r.ld_hit;
	assign pm_load_data = s_r.ld_data;
	assign cpu_halt = s_r.halt;
	assign fl_erase = s_r.st == fsp_pkg::st_erase;
	assign fl_write = s_r.st == fsp_pkg::st_write;
	assign fl_whole = s_r.whole;
	assign fl_sigrow = s_r.sig;
	assign fl_page = s_r.page;
	assign fl_rd_addr = s_r.rd_ptr;
	assign pb_clear = s_r.pb_clr;
	assign flash_section_busy = (fl_erase || fl_write) && !s_r.sig;
	assign fuse_addr = s_r.addr[7:0];
	assign lock_wr = s_r.lock_wr;
	assign lock_wr_data = s_r.data[7:0];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic idle;
	assign idle = s_r.st == fsp_pkg::st_idle;
	sequence seq_apg_erase;
		idle && pm_store && trig_ok && s_r.cmd == fsp_pkg::cmd_er_apg &&
			app_ok;
	endsequence
	sequence seq_wr_apg;
		idle && pm_store && trig_ok && s_r.cmd == fsp_pkg::cmd_wr_apg &&
			app_ok;
	endsequence

	chk_flash_section_busy_busy: assert property (flash_section_busy |-> !idle)
		else $error("section busy without busy");
	chk_page_erase: assert property (seq_apg_erase |=>
		(fl_erase && flash_section_busy && !cpu_halt) [*8])
		else $error("page erase not held");
	chk_write_page: assert property (seq_wr_apg |=> fl_write &&
		fl_page == $past(ptr_page)) else $error("write page wrong");
	chk_bad_page: assert property (idle && pm_store && !app_ok && trig_ok &&
		s_r.cmd == fsp_pkg::cmd_er_apg |=> idle && s_r.abort)
		else $error("bad page not aborted");
	chk_crc_halt: assert property (s_r.st == fsp_pkg::st_crc |->
		cpu_halt) else $error("crc without halt");
	chk_range_lock: assert property (idle && exec && !lock_free &&
		s_r.cmd == fsp_pkg::cmd_crc_rng |=> idle && !cpu_halt)
		else $error("locked range crc ran");
	chk_app_erase: assert property (idle && pm_store && trig_ok &&
		app_ok && s_r.cmd == fsp_pkg::cmd_er_app |=>
		(fl_whole && cpu_halt && fl_erase) [*8]) else $error("app erase");
	chk_erase_write: assert property (fl_erase && s_r.then_wr &&
		s_r.cnt == CNT_W'(0) |=> fl_write) else $error("no write after erase");
	chk_sig_clear: assert property (s_r.st == fsp_pkg::st_clr |->
		!cpu_halt && !flash_section_busy) else $error("clear phase halted");
	chk_sig_read: assert property (idle && pm_load &&
		s_r.cmd == fsp_pkg::cmd_rd_usig |=> pm_load_hit &&
		pm_load_data == $past(sig_user_data)) else $error("sig read");
	chk_lock_nohalt: assert property (s_r.st == fsp_pkg::st_lock |->
		!cpu_halt) else $error("lock write halted");
	chk_fuse_data: assert property (s_r.st == fsp_pkg::st_fuse &&
		s_r.cnt == CNT_W'(0) |=> idle && s_r.data[7:0] == $past(fuse_data))
		else $error("fuse result wrong");
	chk_guard_refuse: assert property (idle && pm_store &&
		s_r.guard == 4'h0 && f_prot(s_r.cmd) |=> idle)
		else $error("unguarded trigger taken");
endmodule

/* design/fsp_cfg.svh */
// Behaviour
// - Page write stores page buffer into page named by pointer page field only.
// - Page write or erase holds busy and flash_section_busy until done.
// - Range CRC sets busy, halts processor, leaves checksum in data reg.
// - Range CRC aborts unless all boot lock bits are unprogrammed.
// - Erase-application erases whole section, busy and processor halted throughout.
// - Section page erase clears one pointer-selected page, busy and section busy set.
// - Invalid or wrong-section page address aborts section page commands.
// - Erase-and-write erases then programs the page atomically, busy flags set.
// - Section CRC on execute sets busy, halts processor, leaves checksum.
// - Signature row erase on store keeps busy and processor halted until done.
// - Signature write halted, then page buffer clear with processor running, busy held.
// - Signature read command redirects program load to signature row byte.
// - Triggers: execute bit, program load, or program store per command.
// - Command 0x00 no operation, 0x07 read fuses, 0x08 write lock bits.
// - Read fuses halts, unprotected; write lock bits no halt, protected.
// - Fuse read uses address reg, lock write takes its value from data reg; fuse result into data reg.
// - Commands 0x22 erase, 0x24 write, 0x25 erase-write application page.
// - Commands 0x3a range CRC, 0x38 application CRC, 0x39 boot CRC.
// - Range CRC addresses are flash byte addresses.
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FSP_OFF_CMD 8'h00
`define FSP_OFF_CTRLA 8'h04
`define FSP_OFF_STATUS 8'h08
`define FSP_OFF_ADDR 8'h0c
`define FSP_OFF_DATA 8'h10
`define FSP_OFF_GUARD 8'h14
// ----------------------------------------
// fields and values
// ----------------------------------------
`define FSP_CTRLA_EXEC 0
`define FSP_ST_BUSY 0
`define FSP_ST_FLASH_SECTION_BUSY 1
`define FSP_ST_HALT 2
`define FSP_ST_ABORT 3
`define FSP_ST_GUARD 4
`define FSP_GUARD_KEY 8'hd8
`define FSP_CMD_RST 7'h00
`define FSP_RESP_OK 2'b00
`define FSP_RESP_ERR 2'b10
// ----------------------------------------
// timing counts in cycles
// ----------------------------------------
`define FSP_GUARD_CYC 4
`define FSP_ERASE_CYC 16
`define FSP_WRITE_CYC 16
`define FSP_CLR_CYC 4
`define FSP_FUSE_CYC 2
`define FSP_LOCK_CYC 4
`endif

/* design/fsp_pkg.sv */
package fsp_pkg;
	typedef enum logic [6:0] {
		cmd_nop = 7'h00, cmd_rd_usig = 7'h01, cmd_rd_psig = 7'h02,
		cmd_rd_fuse = 7'h07, cmd_wr_lock = 7'h08, cmd_er_usig = 7'h18,
		cmd_wr_usig = 7'h1a, cmd_er_app = 7'h20, cmd_er_apg = 7'h22,
		cmd_wr_apg = 7'h24, cmd_ew_apg = 7'h25, cmd_er_bpg = 7'h2a,
		cmd_wr_bpg = 7'h2c, cmd_ew_bpg = 7'h2d, cmd_crc_app = 7'h38,
		cmd_crc_boot = 7'h39, cmd_crc_rng = 7'h3a
	} fsp_cmd_e;
	typedef enum logic [1:0] {
		trg_none, trg_exec, trg_store, trg_load
	} fsp_trig_e;
	typedef enum logic [2:0] {
		st_idle, st_erase, st_write, st_crc, st_clr, st_fuse, st_lock
	} fsp_state_e;
endpackage

/* design/fsp_crc16.sv */
module fsp_crc16 (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// byte stream
	input wire logic init,
	input wire logic en,
	input wire logic [7:0] din,
	// result
	output logic [15:0] crc
);
	// ----------------------------------------
	// byte update, polynomial 0x1021
	// ----------------------------------------
	function automatic logic [15:0] f_upd(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
		end
		return r;
	endfunction

	logic [15:0] crc_r;
	logic [15:0] crc_nxt;

	always_comb begin
		crc_nxt = crc_r;
		if (init) begin
			crc_nxt = 16'hffff;
		end else if (en) begin
			crc_nxt = f_upd(crc_r, din);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_r <= 16'hffff;
		end else begin
			crc_r <= crc_nxt;
		end
	end

	assign crc = crc_r;
endmodule

/* bench/fsp_flash_model.sv */
module fsp_flash_model (
	// clock
	input wire logic aclk,
	// flash read port
	input wire logic [15:0] fl_rd_addr,
	output logic [7:0] fl_rd_data,
	// rows, fuses, locks
	input wire logic [15:0] pm_ptr,
	output logic [7:0] sig_user_data,
	output logic [7:0] sig_prod_data,
	input wire logic [7:0] fuse_addr,
	output logic [7:0] fuse_data,
	input wire logic lock_on,
	output logic [1:0] boot_lock_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	// synchronous array read, one cycle after the address
	always_ff @(posedge aclk) begin
		fl_rd_data <= fl_rd_addr[7:0] ^ fl_rd_addr[15:8] ^ 8'h5c;
	end
	assign sig_user_data = ~pm_ptr[7:0];
	assign sig_prod_data = pm_ptr[7:0] ^ 8'h3c;
	assign fuse_data = fuse_addr + 8'h30;
	assign boot_lock_bits = lock_on ? 2'b00 : 2'b11;
endmodule

/* bench/test_flash_self_program_sequencer.sv */
`include "fsp_cfg.svh"
module test_flash_self_program_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, pm_store = 0, pm_load = 0, lock_on = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, pm_load_hit, cpu_halt;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, boot_lock_bits, rr;
	logic [15:0] pm_ptr = 0, fl_rd_addr;
	logic fl_erase, fl_write, fl_whole, fl_sigrow, pb_clear, lock_wr;
	logic flash_section_busy;
	logic [7:0] pm_load_data, fl_page, fl_rd_data, sig_user_data;
	logic [7:0] sig_prod_data, fuse_addr, fuse_data, lock_wr_data, pg, ld_d, lk_d;
	int fails = 0, checks_done = 0, cyc = 0;
	int n[8];
	fsp_seq #(.NUM_PAGES(16), .BOOT_PAGE(12), .ERASE_CYC(8), .WRITE_CYC(8))
	dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pm_store, .pm_load, .pm_ptr,
		.pm_load_hit, .pm_load_data, .cpu_halt, .fl_erase, .fl_write,
		.fl_whole, .fl_sigrow, .fl_page, .fl_rd_addr, .fl_rd_data, .pb_clear,
		.flash_section_busy, .sig_user_data, .sig_prod_data, .fuse_addr,
		.fuse_data, .lock_wr, .lock_wr_data, .boot_lock_bits);
	fsp_flash_model fm (.aclk, .fl_rd_addr, .fl_rd_data, .pm_ptr,
		.sig_user_data, .sig_prod_data, .fuse_addr, .fuse_data, .lock_on,
		.boot_lock_bits);
	always #4 aclk = ~aclk;
	// ----------------
	// monitor and watchdog
	// ----------------
	always @(posedge aclk) begin
		n[0] += fl_erase;
		n[1] += fl_write;
		n[2] += flash_section_busy;
		n[3] += cpu_halt;
		n[4] += pb_clear;
		n[5] += lock_wr;
		n[6] += pm_load_hit;
		n[7] += fl_whole | fl_sigrow;
		if (fl_erase | fl_write) pg = fl_page;
		if (pm_load_hit) ld_d = pm_load_data;
		if (lock_wr) lk_d = lock_wr_data;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			wrap_up();
		end
	end
	// ----------------
	// tasks
	// ----------------
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic idle();
		do rdr(8'h08); while (rd[0] !== 1'b0);
	endtask
	task automatic pulse(input logic st, input logic [15:0] p);
		@(posedge aclk);
		pm_store <= st;
		pm_load <= !st;
		pm_ptr <= p;
		@(posedge aclk);
		pm_store <= 0;
		pm_load <= 0;
	endtask
	task automatic page_op(input logic [6:0] c, input logic [15:0] p,
		input logic g, input int e, input int w, input logic [7:0] ep,
		input int f, input int h, input logic ab);
		n = '{default: 0};
		wr(8'h00, {25'h0, c});
		if (g) wr(8'h14, {24'h0, `FSP_GUARD_KEY});
		pulse(1, p);
		idle();
		cmp("erase cycles", e, n[0]);
		cmp("write cycles", w, n[1]);
		if (f >= 0) cmp("section busy", f, n[2]);
		if (f > 0) cmp("page", ep, pg);
		if (h >= 0) cmp("halt cycles", h, n[3]);
		cmp("abort", ab, rd[3]);
		wr(8'h08, 32'h8);
	endtask
	function automatic logic [15:0] crc_b(input logic [15:0] x, input logic [7:0] d);
		x = x ^ {d, 8'h0};
		for (int i = 0; i < 8; i++) x = {x[14:0], 1'b0} ^ (x[15] ? 16'h1021 : 16'h0);
		return x;
	endfunction
	task automatic crc_op(input logic [6:0] c, input int s, input int e,
		input logic ab);
		logic [15:0] x;
		x = 16'hffff;
		for (int a = s; a <= e; a++) x = crc_b(x, a[7:0] ^ a[15:8] ^ 8'h5c);
		wr(8'h0c, s);
		wr(8'h10, e);
		wr(8'h00, {25'h0, c});
		n = '{default: 0};
		wr(8'h14, {24'h0, `FSP_GUARD_KEY});
		wr(8'h04, 32'h1);
		idle();
		cmp("crc abort", ab, rd[3]);
		rdr(8'h10);
		if (!ab) cmp("crc", {16'h0, x}, rd);
		if (!ab) cmp("crc halt", 1, n[3] > e - s);
		wr(8'h08, 32'h8);
	endtask
	task automatic misc();
		rdr(8'h00);
		cmp("cmd reset", 0, rd);
		rdr(8'h40);
		cmp("unmapped resp", 2'b10, rr);
		cmp("unmapped data", 0, rd);
		wr(8'h40, 32'h0);
		cmp("unmapped write", 2'b10, rr);
		wr(8'h0c, 32'h5);
		wr(8'h00, 32'h7);
		n = '{default: 0};
		wr(8'h04, 32'h1);
		idle();
		rdr(8'h10);
		cmp("fuse data", 8'h35, rd[7:0]);
		cmp("fuse halt", `FSP_FUSE_CYC, n[3]);
		wr(8'h10, 32'ha5);
		wr(8'h00, 32'h8);
		n = '{default: 0};
		wr(8'h14, {24'h0, `FSP_GUARD_KEY});
		wr(8'h04, 32'h1);
		idle();
		cmp("lock write", {1'b1, 8'ha5, 8'h0}, {n[5][0], lk_d, n[3][7:0]});
		// loads hit the row only while a row read command is selected; the load under command 0 must not
		for (int k = 1; k >= 0; k--) begin
			wr(8'h00, 32'h1 + k);
			pulse(0, 16'h0034);
			repeat (2) @(posedge aclk);
			cmp("row byte", k ? 8'h08 : 8'hcb, ld_d);
		end
		wr(8'h00, 32'h0);
		pulse(0, 16'h0034);
		repeat (2) @(posedge aclk);
		cmp("load hits", 2, n[6]);
	endtask
	task automatic wrap_up();
		if (fails == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----------------
	// sequence
	// ----------------
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		misc();
		page_op(7'h22, 16'h03a5, 1, 8, 0, 8'h03, 8, 0, 0);
		page_op(7'h24, 16'h0aff, 1, 0, 8, 8'h0a, 8, 0, 0);
		page_op(7'h25, 16'h0b00, 1, 8, 8, 8'h0b, 16, 0, 0);
		page_op(7'h2a, 16'h0c12, 1, 8, 0, 8'h0c, 8, -1, 0);
		page_op(7'h2c, 16'h0f77, 1, 0, 8, 8'h0f, 8, -1, 0);
		page_op(7'h2d, 16'h0d01, 1, 8, 8, 8'h0d, 16, -1, 0);
		page_op(7'h22, 16'h0c00, 1, 0, 0, 8'h0, 0, 0, 1);
		page_op(7'h2d, 16'h0500, 1, 0, 0, 8'h0, 0, 0, 1);
		page_op(7'h24, 16'h1000, 1, 0, 0, 8'h0, 0, 0, 1);
		page_op(7'h2a, 16'h0c00, 0, 0, 0, 8'h0, 0, 0, 0);
		page_op(7'h22, 16'h0300, 0, 0, 0, 8'h0, 0, 0, 0);
		page_op(7'h20, 16'h0c00, 1, 0, 0, 8'h0, 0, 0, 1);
		page_op(7'h20, 16'h0400, 1, 8, 0, 8'h0, -1, 8, 0);
		cmp("whole erase", 8, n[7]);
		page_op(7'h18, 16'h0000, 1, 8, 0, 8'h0, -1, 8, 0);
		page_op(7'h1a, 16'h0000, 1, 0, 8, 8'h0, -1, 8, 0);
		cmp("buffer clear", 1, n[4]);
		crc_op(7'h3a, 16'h0101, 16'h0204, 0);
		crc_op(7'h3a, 16'h0200, 16'h0100, 1);
		lock_on <= 1;
		repeat (3) @(posedge aclk);
		crc_op(7'h3a, 16'h0000, 16'h0010, 1);
		lock_on <= 0;
		repeat (3) @(posedge aclk);
		crc_op(7'h38, 0, 3071, 0);
		crc_op(7'h39, 3072, 4095, 0);
		wrap_up();
	end
endmodule
